// ### hdl/lbc_ctrl.v
// Operation
// (R1) Maskable request is a high level sampled in each instruction's last clock.
// (R2) Maskable request is ignored while the interrupt enable flag is clear.
// (R3) Maskable request passes a two-stage synchroniser before use.
// (R4) Serviced interrupt fetches its handler address from the memory vector table.
// (R5) Wait instruction finishes when test is low, otherwise idles and rechecks.
// (R6) Test input is synchronised every clock on the rising edge.
// (R7) Non-maskable request is edge triggered and uses vector 2.
// (R8) Its rising edge starts service after the current instruction; synchronised.
// (R9) Enable flag has no effect on the non-maskable request.
// (R10) Reset pin aborts at once; restart follows its release; synchronised.
// (R11) Reset source holds reset high at least four clocks.
// (R12) Mode select high chooses minimum-mode pin functions.
// (R13) Memory/IO line high for memory, low for IO, from preceding T4 to last T4.
// (R14) Memory/IO line floats at logic one during hold acknowledge.
// (R15) Write strobe low in T2, T3 and wait states of write cycles only.
// (R16) Write strobe floats at logic one during hold acknowledge.
// (R17) Acknowledge strobe low in T2, T3 and wait states of each acknowledge cycle.
// (R18) Acknowledge strobe is always driven, never floated.
// (R19) Address latch pulse high only in T1 of every bus cycle.
// (R20) Address latch pulse is always driven, never floated.
// (R21) Hold grant rises together with floating of bus control lines.
// (R22) Bus cycles run T1 to T4 with wait states after T3 while ready is low.
`timescale 1ns/1ps
`include "lbc_defines.vh"

module lbc_ctrl #(
	parameter VEC_W  = 8,
	parameter ADDR_W = 20
) (
	// Clock and reset
	input  wire              clk_i,
	input  wire              sys_rst_i,
	// Device pins in
	input  wire              reset_pin_i,
	input  wire              maskable_irq_in_i,
	input  wire              nmi_i,
	input  wire              test_n_i,
	input  wire              min_max_select_i,
	input  wire              ready_i,
	input  wire              hold_req_i,
	input  wire [VEC_W-1:0]  vector_data_i,
	// Core side
	input  wire              instr_end_i,
	input  wire              irq_enable_i,
	input  wire              wait_instr_i,
	input  wire              bus_req_i,
	input  wire              bus_write_i,
	input  wire              bus_mem_i,
	// Device pins out
	output wire              mem_io_o,
	output wire              mem_io_oe_o,
	output wire              write_n_o,
	output wire              write_n_oe_o,
	output wire              irq_ack_strobe_n_o,
	output wire              ale_o,
	output wire              hold_grant_out_o,
	// Core side out
	output wire              core_reset_o,
	output wire              min_mode_o,
	output wire              bus_ack_o,
	output wire              bus_done_o,
	output wire [2:0]        bus_state_o,
	output wire              irq_busy_o,
	output wire              vector_fetch_o,
	output wire [VEC_W-1:0]  vector_num_o,
	output wire [ADDR_W-1:0] vector_addr_o,
	output wire              wait_idle_o,
	output wire              wait_done_o
);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	reg irq_s1_reg;
	reg irq_s2_reg;
	reg nmi_s1_reg;
	reg nmi_s2_reg;
	reg nmi_s3_reg;
	reg test_s1_reg;
	reg test_s2_reg;
	reg rst_s1_reg;
	reg rst_s2_reg;

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			irq_s1_reg  <= 1'b0;
			irq_s2_reg  <= 1'b0;
			nmi_s1_reg  <= 1'b0;
			nmi_s2_reg  <= 1'b0;
			nmi_s3_reg  <= 1'b0;
			test_s1_reg <= 1'b1;
			test_s2_reg <= 1'b1;
			rst_s1_reg  <= 1'b1;
			rst_s2_reg  <= 1'b1;
		end else begin
			irq_s1_reg  <= maskable_irq_in_i; // [R3]
			irq_s2_reg  <= irq_s1_reg;        // [R3]
			nmi_s1_reg  <= nmi_i;             // [R8]
			nmi_s2_reg  <= nmi_s1_reg;
			nmi_s3_reg  <= nmi_s2_reg;
			test_s1_reg <= test_n_i;          // [R6]
			test_s2_reg <= test_s1_reg;       // [R6]
			rst_s1_reg  <= reset_pin_i;       // [R10]
			rst_s2_reg  <= rst_s1_reg;        // [R10]
		end
	end

	// Edge seen between the second and third stage only
	wire nmi_rise = nmi_s2_reg & ~nmi_s3_reg; // [R7]
	wire abort    = sys_rst_i | rst_s2_reg;   // [R10]

	// ----------------------------------------
	// Mode select
	// ----------------------------------------
	// Caught while reset is held; a strap is not expected to move later
	reg min_mode_reg;

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			min_mode_reg <= 1'b1;
		end else if (rst_s2_reg) begin
			min_mode_reg <= min_max_select_i; // [R12]
		end
	end

	// ----------------------------------------
	// Interrupt arbitration
	// ----------------------------------------
	reg              nmi_pend_reg;
	reg              irq_ack_strobe_n_pend_reg;
	reg              fetch_reg;
	reg [VEC_W-1:0]  vec_reg;
	wire             take_nmi;
	wire             take_irq;
	wire             irq_ack_strobe_n_end;

	// Non-maskable wins over maskable at an instruction boundary
	assign take_nmi = instr_end_i & nmi_pend_reg & ~irq_ack_strobe_n_pend_reg; // [R8] [R9]
	assign take_irq = instr_end_i & ~nmi_pend_reg & ~irq_ack_strobe_n_pend_reg
		& irq_s2_reg & irq_enable_i; // [R1] [R2]

	always @(posedge clk_i) begin
		if (abort) begin
			nmi_pend_reg <= 1'b0;
		end else if (nmi_rise) begin
			nmi_pend_reg <= 1'b1; // Set wins over the clear [R7]
		end else if (take_nmi) begin
			nmi_pend_reg <= 1'b0;
		end
	end

	always @(posedge clk_i) begin
		if (abort) begin
			irq_ack_strobe_n_pend_reg <= 1'b0;
		end else if (take_irq) begin
			irq_ack_strobe_n_pend_reg <= 1'b1; // [R1]
		end else if (irq_ack_strobe_n_end) begin
			irq_ack_strobe_n_pend_reg <= 1'b0;
		end
	end

	always @(posedge clk_i) begin
		if (abort) begin
			fetch_reg <= 1'b0;
			vec_reg   <= `LBC_RST_VECTOR;
		end else begin
			fetch_reg <= take_nmi | irq_ack_strobe_n_end; // [R4]
			if (take_nmi) begin
				vec_reg <= `LBC_NMI_VECTOR; // [R7]
			end else if (irq_ack_strobe_n_end) begin
				vec_reg <= vector_data_i; // [R17]
			end
		end
	end

	// ----------------------------------------
	// Wait instruction
	// ----------------------------------------
	assign wait_done_o = wait_instr_i & ~test_s2_reg & ~abort; // [R5]
	assign wait_idle_o = wait_instr_i & test_s2_reg & ~abort;  // [R5]

	// ----------------------------------------
	// Bus state machine
	// ----------------------------------------
	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg       cyc_wr_reg;
	reg       cyc_irq_ack_strobe_n_reg;
	reg       mem_io_reg;
	reg       write_n_reg;
	reg       irq_ack_strobe_n_n_reg;
	reg       ale_reg;
	reg       grant_reg;
	wire      start;
	wire      core_start;
	wire      data_phase;

	// Acknowledge cycles go ahead of core requests
	assign start      = irq_ack_strobe_n_pend_reg | bus_req_i;
	assign core_start = (state_reg == `LBC_ST_IDLE) & ~hold_req_i
		& ~irq_ack_strobe_n_pend_reg & bus_req_i & ~abort;
	assign data_phase = (state_reg == `LBC_ST_T3) | (state_reg == `LBC_ST_TW);
	assign irq_ack_strobe_n_end   = data_phase & ready_i & cyc_irq_ack_strobe_n_reg;

	always @* begin
		state_next = state_reg;
		case (state_reg)
			`LBC_ST_IDLE: begin
				if (hold_req_i) begin
					state_next = `LBC_ST_HOLD; // [R21]
				end else if (start) begin
					state_next = `LBC_ST_PRE; // [R13]
				end
			end
			`LBC_ST_PRE: begin
				state_next = `LBC_ST_T1; // [R22]
			end
			`LBC_ST_T1: begin
				state_next = `LBC_ST_T2; // [R22]
			end
			`LBC_ST_T2: begin
				state_next = `LBC_ST_T3; // [R22]
			end
			`LBC_ST_T3, `LBC_ST_TW: begin
				state_next = ready_i ? `LBC_ST_T4 : `LBC_ST_TW; // [R22]
			end
			`LBC_ST_T4: begin
				state_next = hold_req_i ? `LBC_ST_HOLD : `LBC_ST_IDLE; // [R21]
			end
			`LBC_ST_HOLD: begin
				if (!hold_req_i) begin
					state_next = `LBC_ST_IDLE;
				end
			end
			default: begin
				state_next = `LBC_ST_IDLE;
			end
		endcase
	end

	always @(posedge clk_i) begin
		if (abort) begin
			state_reg <= `LBC_ST_IDLE; // [R10]
		end else begin
			state_reg <= state_next;
		end
	end

	// Cycle kind is latched as the preceding T4 is entered
	always @(posedge clk_i) begin
		if (abort) begin
			cyc_wr_reg   <= 1'b0;
			cyc_irq_ack_strobe_n_reg <= 1'b0;
			mem_io_reg   <= `LBC_RST_MEMIO;
		end else if (state_reg == `LBC_ST_IDLE && state_next == `LBC_ST_PRE) begin
			cyc_irq_ack_strobe_n_reg <= irq_ack_strobe_n_pend_reg;
			cyc_wr_reg   <= ~irq_ack_strobe_n_pend_reg & bus_write_i;
			// Acknowledge cycles report as IO
			mem_io_reg   <= ~irq_ack_strobe_n_pend_reg & bus_mem_i; // [R13]
		end
	end

	// ----------------------------------------
	// Registered strobes
	// ----------------------------------------
	// ALE spans the whole T1 clock; the low-phase window needs the
	// asymmetric clock, which a single-edge design cannot see
	wire nx_strobe = (state_next == `LBC_ST_T2) | (state_next == `LBC_ST_T3)
		| (state_next == `LBC_ST_TW);

	always @(posedge clk_i) begin
		if (abort) begin
			write_n_reg <= `LBC_RST_STROBE;
			irq_ack_strobe_n_n_reg  <= `LBC_RST_STROBE;
			ale_reg     <= 1'b0;
			grant_reg   <= 1'b0;
		end else begin
			write_n_reg <= ~(nx_strobe & cyc_wr_reg);   // [R15]
			irq_ack_strobe_n_n_reg  <= ~(nx_strobe & cyc_irq_ack_strobe_n_reg); // [R17]
			ale_reg     <= (state_next == `LBC_ST_T1);  // [R19]
			grant_reg   <= (state_next == `LBC_ST_HOLD); // [R21]
		end
	end

	// ----------------------------------------
	// Pin drivers
	// ----------------------------------------
	// In maximum mode the minimum-mode pins stay passive
	wire drive = min_mode_reg & ~grant_reg;

	assign mem_io_o           = drive ? mem_io_reg : 1'b1;   // [R14]
	assign mem_io_oe_o        = drive;                       // [R14] [R21]
	assign write_n_o          = drive ? write_n_reg : 1'b1;  // [R16]
	assign write_n_oe_o       = drive;                       // [R16] [R21]
	assign irq_ack_strobe_n_o = min_mode_reg ? irq_ack_strobe_n_n_reg : 1'b1; // [R18]
	assign ale_o              = min_mode_reg & ale_reg;      // [R20]
	assign hold_grant_out_o   = min_mode_reg & grant_reg;    // [R21]

	// ----------------------------------------
	// Core status
	// ----------------------------------------
	assign core_reset_o   = abort;
	assign min_mode_o     = min_mode_reg;
	assign bus_ack_o      = core_start;
	assign bus_done_o     = (state_reg == `LBC_ST_T4) & ~cyc_irq_ack_strobe_n_reg;
	assign bus_state_o    = state_reg;
	assign irq_busy_o     = irq_ack_strobe_n_pend_reg;
	assign vector_fetch_o = fetch_reg;
	assign vector_num_o   = vec_reg;
	// Table entries are four bytes each
	assign vector_addr_o  = {{(ADDR_W-VEC_W-`LBC_VEC_SHIFT){1'b0}}, vec_reg,
		{`LBC_VEC_SHIFT{1'b0}}}; // [R4]

endmodule // lbc_ctrl

// ### hdl/lbc_defines.vh
`ifndef LBC_DEFINES_VH
`define LBC_DEFINES_VH

// ----------------------------------------
// Bus state codes
// ----------------------------------------
`define LBC_ST_IDLE 3'h0
`define LBC_ST_PRE  3'h1
`define LBC_ST_T1   3'h2
`define LBC_ST_T2   3'h3
`define LBC_ST_T3   3'h4
`define LBC_ST_TW   3'h5
`define LBC_ST_T4   3'h6
`define LBC_ST_HOLD 3'h7

// ----------------------------------------
// Interrupt constants
// ----------------------------------------
`define LBC_NMI_VECTOR 8'h02
`define LBC_VEC_SHIFT  2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LBC_RST_STROBE 1'b1
`define LBC_RST_MEMIO  1'b1
`define LBC_RST_VECTOR 8'h00

`endif

// ### test/lbc_bus_partner.sv
`timescale 1ns/1ps
module lbc_bus_partner (
	// Bus seen
	input  wire       clk_i,
	input  wire [2:0] bus_state_i,
	input  wire       ack_strobe_n_i,
	input  wire [3:0] waits_i,
	input  wire [7:0] vector_i,
	// Answer
	output reg        ready_o,
	output reg  [7:0] vector_o
);
	reg [3:0] cnt_reg;
	initial begin
		ready_o = 1'b1;
		vector_o = 8'h00;
		cnt_reg = 4'h0;
	end
	always @(posedge clk_i) begin
		if (bus_state_i == 3'h3) begin
			cnt_reg <= waits_i;
			ready_o <= (waits_i == 4'h0);
		end else if (bus_state_i == 3'h4 || bus_state_i == 3'h5) begin
			cnt_reg <= cnt_reg - 4'h1;
			ready_o <= (cnt_reg <= 4'h1);
		end
		// Churn when not read so a late capture shows up
		vector_o <= ack_strobe_n_i ? ~vector_o : vector_i;
	end
endmodule // lbc_bus_partner

// ### test/lbc_ctrl_sva.sv
`timescale 1ns/1ps
module lbc_ctrl_sva (
	// Watched ports
	input wire       clk_i,
	input wire       sys_rst_i,
	input wire       ready_i,
	input wire       bus_mem_i,
	input wire       bus_ack_o,
	input wire       bus_done_o,
	input wire [2:0] bus_state_o,
	input wire       mem_io_o,
	input wire       mem_io_oe_o,
	input wire       write_n_o,
	input wire       write_n_oe_o,
	input wire       irq_ack_strobe_n_o,
	input wire       ale_o,
	input wire       hold_grant_out_o,
	input wire       core_reset_o
);
	default clocking @(posedge clk_i); endclocking
	// Pin reset aborts too, so it silences the cycle checks
	default disable iff (core_reset_o);
	// ----------------------------------------
	// Bus cycle steps
	// ----------------------------------------
	sequence s_addr;
		bus_state_o == 3'h1 ##1 bus_state_o == 3'h2;
	endsequence
	sequence s_data;
		bus_state_o == 3'h3 ##1 bus_state_o == 3'h4;
	endsequence
	a_cycle_order: assert property (bus_ack_o |=> s_addr ##1 s_data)
		else $error("cycle order");
	a_wait_step: assert property (bus_state_o inside {3'h4, 3'h5} |=> bus_state_o == ($past(ready_i) ? 3'h6 : 3'h5))
		else $error("wait step");
	a_done_t4: assert property (bus_done_o |-> bus_state_o == 3'h6)
		else $error("done outside T4");
	a_ale_t1: assert property (ale_o |-> bus_state_o == 3'h2 ##1 !ale_o)
		else $error("ale outside T1");
	a_ale_every: assert property (bus_state_o == 3'h1 |=> ale_o)
		else $error("ale missing");
	a_wr_window: assert property (!write_n_o |-> bus_state_o inside {3'h3, 3'h4, 3'h5})
		else $error("write strobe window");
	a_ack_window: assert property (!irq_ack_strobe_n_o |-> bus_state_o inside {3'h3, 3'h4, 3'h5} && write_n_o)
		else $error("ack strobe window");
	a_memio_kind: assert property (bus_ack_o |=> mem_io_o == $past(bus_mem_i))
		else $error("mem io kind");
	a_memio_hold: assert property (bus_state_o inside {3'h2, 3'h3, 3'h4, 3'h5, 3'h6} |-> $stable(mem_io_o))
		else $error("mem io moved");
	a_hold_float: assert property (hold_grant_out_o |-> !mem_io_oe_o && !write_n_oe_o && mem_io_o && write_n_o)
		else $error("hold float");
	a_grant_float: assert property ($rose(hold_grant_out_o) |-> $fell(mem_io_oe_o) && $fell(write_n_oe_o))
		else $error("grant not with float");
	a_rst_abort: assert property (disable iff (sys_rst_i) core_reset_o |=> !ale_o && write_n_o && irq_ack_strobe_n_o)
		else $error("reset no abort");
endmodule // lbc_ctrl_sva

bind lbc_ctrl lbc_ctrl_sva u_sva (.*);

// ### test/tb.sv
`timescale 1ns/1ps
module tb;
	reg clk_i = 1'b0, sys_rst_i = 1'b1, reset_pin_i = 1'b0, maskable_irq_in_i = 1'b0, nmi_i = 1'b0;
	reg test_n_i = 1'b1, min_max_select_i = 1'b1, hold_req_i = 1'b0, instr_end_i = 1'b0;
	reg irq_enable_i = 1'b0, wait_instr_i = 1'b0, bus_req_i = 1'b0, bus_write_i = 1'b0, bus_mem_i = 1'b0;
	wire ready_i, mem_io_o, mem_io_oe_o, write_n_o, write_n_oe_o, irq_ack_strobe_n_o, ale_o;
	wire hold_grant_out_o, core_reset_o, min_mode_o, bus_ack_o, bus_done_o, irq_busy_o;
	wire vector_fetch_o, wait_idle_o, wait_done_o;
	wire [2:0] bus_state_o;
	wire [7:0] vector_data_i, vector_num_o;
	wire [19:0] vector_addr_o;
	integer seed = 32'hBB9643C7, error_cnt = 0, n_tests = 0, i, n, lo, k, b;
	reg [3:0] waits = 4'h0;
	reg [7:0] vec = 8'h00;
	reg w, m;
	integer exp_q[$];
	always #50 clk_i = ~clk_i;
	lbc_ctrl u_dut (.*);
	lbc_bus_partner u_partner (.clk_i(clk_i), .bus_state_i(bus_state_o), .ack_strobe_n_i(irq_ack_strobe_n_o),
		.waits_i(waits), .vector_i(vec), .ready_o(ready_i), .vector_o(vector_data_i));
	// ----------------------------------------
	// Checks and bus tasks
	// ----------------------------------------
	task chk(input string nm, input [31:0] e, input [31:0] g);
		begin
			n_tests = n_tests + 1;
			if (g !== e) begin
				error_cnt = error_cnt + 1;
				$display("Error %s expected %0h seen %0h", nm, e, g);
			end
		end
	endtask
	task complete_run;
		begin
			$display("tests %0d errors %0d", n_tests, error_cnt);
			if (error_cnt == 0 && n_tests > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	task rst_pin(input mode);
		begin
			@(posedge clk_i);
			reset_pin_i <= 1'b1;
			min_max_select_i <= mode;
			repeat (4) @(posedge clk_i);
			@(negedge clk_i);
			chk("core_reset", 1, core_reset_o);
			@(posedge clk_i);
			reset_pin_i <= 1'b0;
			repeat (3) @(posedge clk_i);
			@(negedge clk_i);
			chk("core_reset", 0, core_reset_o);
			chk("min_mode", mode, min_mode_o);
			chk("passive", mode ? 3 : 0, {mem_io_oe_o, write_n_oe_o});
			$display("reset test end");
		end
	endtask
	task bus_cyc;
		begin
			w = $random(seed);
			m = $random(seed);
			waits = {$random(seed)} % 3;
			@(posedge clk_i);
			bus_req_i <= 1'b1;
			bus_write_i <= w;
			bus_mem_i <= m;
			@(negedge clk_i);
			for (n = 0; n < 20 && bus_ack_o !== 1'b1; n = n + 1)
				@(negedge clk_i);
			if (n == 20) begin
				error_cnt = error_cnt + 1;
				complete_run;
			end
			@(posedge clk_i);
			bus_req_i <= 1'b0;
			lo = 0;
			for (i = 1; i < 20 && bus_done_o !== 1'b1; i = i + 1) begin
				@(negedge clk_i);
				lo = lo + (write_n_o === 1'b0);
			end
			if (i == 20) begin
				error_cnt = error_cnt + 1;
				complete_run;
			end
			chk("cycles", 6 + waits, i);
			chk("wr_low", w ? 2 + waits : 0, lo);
			chk("mem_io", m, mem_io_o);
			$display("bus test end");
		end
	endtask
	// Kind 0 maskable, 1 non-maskable with flag clear, 2 maskable with flag clear
	task maskable_irq_in(input integer kind);
		begin
			vec = $random(seed);
			waits = {$random(seed)} % 3;
			@(posedge clk_i);
			irq_enable_i <= (kind == 0);
			maskable_irq_in_i <= (kind != 1);
			nmi_i <= (kind == 1);
			repeat (3) @(posedge clk_i);
			instr_end_i <= 1'b1;
			if (kind == 0)
				exp_q.push_back(vec);
			if (kind == 1)
				exp_q.push_back(2);
			@(posedge clk_i);
			instr_end_i <= 1'b0;
			maskable_irq_in_i <= 1'b0;
			nmi_i <= 1'b0;
			lo = 0;
			b = 0;
			for (i = 0; i < 15 && vector_fetch_o !== 1'b1; i = i + 1) begin
				@(negedge clk_i);
				lo = lo + (irq_ack_strobe_n_o === 1'b0);
				b = b + (irq_busy_o === 1'b1);
			end
			if (kind != 2 && i == 15) begin
				error_cnt = error_cnt + 1;
				complete_run;
			end
			chk("ack_low", kind == 0 ? 2 + waits : 0, lo);
			chk("busy", kind == 0 ? 5 + waits : 0, b);
			if (kind == 2)
				chk("masked", 15, i);
			else begin
				n = exp_q.pop_front();
				chk("vec_num", n, vector_num_o);
				chk("vec_addr", n * 4, vector_addr_o);
			end
			$display("irq test end");
		end
	endtask
	initial begin
		repeat (5) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		rst_pin(1'b0);
		rst_pin(1'b1);
		for (k = 0; k < 8; k = k + 1)
			bus_cyc;
		for (k = 0; k < 6; k = k + 1)
			maskable_irq_in(k % 3);
		@(posedge clk_i);
		wait_instr_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		@(negedge clk_i);
		chk("wait_idle", 1, wait_idle_o);
		@(posedge clk_i);
		test_n_i <= 1'b0;
		@(posedge clk_i);
		@(negedge clk_i);
		chk("wait_done", 0, wait_done_o);
		@(posedge clk_i);
		@(negedge clk_i);
		chk("wait_done", 1, wait_done_o);
		$display("wait test end");
		@(posedge clk_i);
		wait_instr_i <= 1'b0;
		hold_req_i <= 1'b1;
		bus_req_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		chk("grant", 1, hold_grant_out_o);
		chk("float", 0, {mem_io_oe_o, write_n_oe_o, bus_ack_o});
		chk("driven", 2, {irq_ack_strobe_n_o, ale_o});
		@(posedge clk_i);
		hold_req_i <= 1'b0;
		@(posedge clk_i);
		@(negedge clk_i);
		chk("release", 3, {hold_grant_out_o, mem_io_oe_o, write_n_oe_o});
		chk("late_ack", 1, bus_ack_o);
		// The refused request stays up and is taken once hold ends
		@(posedge clk_i);
		bus_req_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		$display("hold test end");
		complete_run;
	end
endmodule // tb
